// ### logic/fsr_flash_seq.sv
// serial flash suspend/resume and security register sequencer
// Behaviour
// - suspend accepted only when not suspended and busy with program/erase
// - suspend ignored when already suspended or not busy
// - suspend sets suspend flag at once, busy drops after latency
// - while suspended, status/security writes, erases, programs rejected
// - suspended op's block is exported so other blocks stay readable
// - reset comes up with suspend released
// - resume accepted only when suspended and not busy
// - resume clears suspend at once, busy back within 200 ns, op finishes
// - resume ignored when no suspend active
// - four 256-byte security registers, programmed apart, all four erased together
// - security erase/program need write enable latch set
// - security erase needs select release exactly after eighth bit
// - security erase self-timed, busy held, latch cleared
// - lock bit set blocks security erase and program until reset
// - security program self-timed, busy held, latch cleared
// - read: code, address, dummy byte, sampled on clock rise
// - read data driven on clock fall
// - read address advances per byte, low ten bits wrap to zero
// - read runs until select rises, then output released
`timescale 1ns/100ps
`default_nettype none
`include "fsr_cfg.svh"
module fsr_flash_seq
  import fsr_pkg::*;
#(
  parameter int SE_TIME_NS = 1000000,
  parameter int PP_TIME_NS = 500000,
  parameter int SUS_TIME_NS = 20000,
  parameter int ARR_TIME_NS = 500000
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SI,
  input wire logic LOCK_REQ,
  output logic SO,
  output logic SO_OE,
  output logic WRITE_IN_PROGRESS_FLAG,
  output logic WRITE_ENABLE_LATCH_FLAG,
  output logic SUS,
  output logic LB,
  output logic [11:0] SUSP_BLOCK
);
  localparam int SE_CYC = SE_TIME_NS / `FSR_CLK_NS;
  localparam int PP_CYC = PP_TIME_NS / `FSR_CLK_NS;
  localparam int SUS_CYC = SUS_TIME_NS / `FSR_CLK_NS;
  localparam int ARR_CYC = ARR_TIME_NS / `FSR_CLK_NS;
  localparam int RES_CYC = `FSR_RESUME_CYC;
  fsr_pins_t s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
  logic [2:0] bit_r, ob_r;
  logic [8:0] byte_r;
  logic [7:0] sh_r, op_r, new_byte, pptr_r;
  logic [23:0] addr_r;
  logic [9:0] rd_addr_r;
  logic [1:0] psel_r;
  logic rd_ok_r;
  logic [7:0] mem_r [0:1023];
  logic [7:0] pbuf_r [0:255];
  fsr_state_t state_r, state_nxt;
  logic [31:0] cnt_r, arr_r;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, byte_done;
  logic op_only, go_write_enable_cmd, go_susp, go_resm, go_sers, go_sprg, go_arr;
  logic blocked, ers_done, prg_done;
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_r <= `FSR_PINS_IDLE;
      s2_r <= `FSR_PINS_IDLE;
      s3_r <= `FSR_PINS_IDLE;
      lvl_r <= `FSR_PINS_IDLE;
    end else begin
      s1_r <= '{cs_n: CS_N, sclk: SCLK, si: SI};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end
  always_comb begin
    lvl_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
  end
  assign sclk_rise = lvl_nxt.sclk & ~lvl_r.sclk & ~lvl_nxt.cs_n;
  assign sclk_fall = ~lvl_nxt.sclk & lvl_r.sclk & ~lvl_nxt.cs_n;
  assign cs_rise = lvl_nxt.cs_n & ~lvl_r.cs_n;
  assign cs_fall = ~lvl_nxt.cs_n & lvl_r.cs_n;
  assign new_byte = {sh_r[6:0], lvl_nxt.si};
  assign byte_done = sclk_rise && (bit_r == 3'h7);
  ////////////////////////////////////////////////////////////////////////
  // serial input: bit and byte counting, opcode and address capture
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bit_r <= 3'h0;
      byte_r <= 9'h000;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      rd_ok_r <= 1'b0;
    end else if (cs_fall) begin
      bit_r <= 3'h0;
      byte_r <= 9'h000;
    end else if (sclk_rise) begin
      sh_r <= new_byte;
      bit_r <= bit_r + 3'h1;
      if (byte_done) begin
        // saturate so an endless read never aliases back to the header
        if (byte_r != 9'h1FF)
          byte_r <= byte_r + 9'h001;
        if (byte_r == 9'h000) begin
          op_r <= new_byte;
          rd_ok_r <= ~WRITE_IN_PROGRESS_FLAG;
        end
        if (byte_r >= 9'h001 && byte_r <= 9'h003)
          addr_r <= {addr_r[15:0], new_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program data staging; array cells only ever clear bits
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pptr_r <= 8'h00;
      for (int i = 0; i < 256; i++)
        pbuf_r[i] <= `FSR_ERASED;
    end else if (cs_fall) begin
      for (int i = 0; i < 256; i++)
        pbuf_r[i] <= `FSR_ERASED;
    end else if (byte_done && op_r == `FSR_OP_SPRG) begin
      if (byte_r == 9'h003)
        pptr_r <= new_byte;
      else if (byte_r >= `FSR_HDR_PRG) begin
        pbuf_r[pptr_r] <= pbuf_r[pptr_r] & new_byte;
        pptr_r <= pptr_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read output shifter
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
      ob_r <= 3'h0;
      rd_addr_r <= 10'h000;
    end else if (cs_rise) begin
      SO_OE <= 1'b0;
    end else if (byte_done && byte_r == 9'h003) begin
      rd_addr_r <= {addr_r[1:0], new_byte};
      ob_r <= 3'h0;
    end else if (sclk_fall && rd_ok_r && op_r == `FSR_OP_SRD
                 && byte_r >= `FSR_HDR_RD) begin
      SO <= mem_r[rd_addr_r][3'h7 - ob_r];
      SO_OE <= 1'b1;
      ob_r <= ob_r + 3'h1;
      if (ob_r == 3'h7)
        rd_addr_r <= rd_addr_r + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command qualification at select release
  assign op_only = cs_rise && byte_r == 9'h001 && bit_r == 3'h0;
  assign go_write_enable_cmd = op_only && op_r == `FSR_OP_WRITE_ENABLE_CMD && !WRITE_IN_PROGRESS_FLAG;
  assign go_susp = op_only && op_r == `FSR_OP_SUSP
                   && state_r == ST_ARR && !SUS;
  assign go_resm = op_only && op_r == `FSR_OP_RESM
                   && state_r == ST_SUSP;
  assign go_sers = op_only && op_r == `FSR_OP_SERS
                   && state_r == ST_IDLE && WRITE_ENABLE_LATCH_FLAG && !LB;
  assign go_sprg = cs_rise && op_r == `FSR_OP_SPRG && bit_r == 3'h0
                   && byte_r > `FSR_HDR_PRG && addr_r[23:10] == 14'h0000
                   && state_r == ST_IDLE && WRITE_ENABLE_LATCH_FLAG && !LB;
  assign go_arr = cs_rise && bit_r == 3'h0 && state_r == ST_IDLE && WRITE_ENABLE_LATCH_FLAG
                  && ((byte_r > `FSR_HDR_PRG && (op_r == `FSR_OP_PP
                      || op_r == `FSR_OP_QPP))
                  || (byte_r == `FSR_HDR_ERS && (op_r == `FSR_OP_SE
                      || op_r == `FSR_OP_BE32 || op_r == `FSR_OP_BE64)));
  // listed for clarity; none of these may start while suspended
  assign blocked = SUS && (op_r == `FSR_OP_WRSR1 || op_r == `FSR_OP_WRSR2
                   || op_r == `FSR_OP_WRSR3 || op_r == `FSR_OP_CE1
                   || op_r == `FSR_OP_CE2);
  assign ers_done = state_r == ST_SERS && cnt_r == 32'h0;
  assign prg_done = state_r == ST_SPRG && cnt_r == 32'h0;
  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go_sers)
          state_nxt = ST_SERS;
        else if (go_sprg)
          state_nxt = ST_SPRG;
        else if (go_arr && !blocked)
          state_nxt = ST_ARR;
      end
      ST_ARR: begin
        if (go_susp)
          state_nxt = ST_SUSW;
        else if (arr_r == 32'h0)
          state_nxt = ST_IDLE;
      end
      ST_SUSW: begin
        if (cnt_r == 32'h0)
          state_nxt = ST_SUSP;
      end
      ST_SUSP: begin
        if (go_resm)
          state_nxt = ST_RESW;
      end
      ST_RESW: begin
        if (cnt_r == 32'h0)
          state_nxt = ST_ARR;
      end
      ST_SERS: begin
        if (cnt_r == 32'h0)
          state_nxt = ST_IDLE;
      end
      ST_SPRG: begin
        if (cnt_r == 32'h0)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
      cnt_r <= 32'h0;
      arr_r <= 32'h0;
      WRITE_IN_PROGRESS_FLAG <= 1'b0;
      SUS <= 1'b0;
      SUSP_BLOCK <= 12'h000;
      psel_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      WRITE_IN_PROGRESS_FLAG <= state_nxt == ST_ARR || state_nxt == ST_SUSW
             || state_nxt == ST_SERS || state_nxt == ST_SPRG;
      if (cnt_r != 32'h0)
        cnt_r <= cnt_r - 32'h1;
      // array timer only runs while the op is active, so it survives suspend
      if (state_r == ST_ARR && arr_r != 32'h0)
        arr_r <= arr_r - 32'h1;
      if (go_sers)
        cnt_r <= 32'(SE_CYC - 1);
      if (go_sprg) begin
        cnt_r <= 32'(PP_CYC - 1);
        psel_r <= addr_r[9:8];
      end
      if (go_arr && !blocked && state_r == ST_IDLE) begin
        arr_r <= 32'(ARR_CYC - 1);
        SUSP_BLOCK <= addr_r[23:12];
      end
      if (go_susp) begin
        SUS <= 1'b1;
        cnt_r <= 32'(SUS_CYC - 1);
      end
      if (go_resm) begin
        SUS <= 1'b0;
        cnt_r <= 32'(RES_CYC - 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write enable latch and lock bit
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WRITE_ENABLE_LATCH_FLAG <= 1'b0;
      LB <= 1'b0;
    end else begin
      if (go_sers || go_sprg || (go_arr && !blocked))
        WRITE_ENABLE_LATCH_FLAG <= 1'b0;
      else if (go_write_enable_cmd)
        WRITE_ENABLE_LATCH_FLAG <= 1'b1;
      if (LOCK_REQ && state_r == ST_IDLE && !SUS)
        LB <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // security register storage, four banks of 256 bytes
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      // flops stand in for cells, so contents do not survive reset
      for (int i = 0; i < 1024; i++)
        mem_r[i] <= `FSR_ERASED;
    end else if (ers_done) begin
      for (int i = 0; i < 1024; i++)
        mem_r[i] <= `FSR_ERASED;
    end else if (prg_done) begin
      for (int j = 0; j < 256; j++)
        mem_r[{psel_r, 8'(j)}] <= mem_r[{psel_r, 8'(j)}] & pbuf_r[j];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  susp_accept_a: assert property (go_susp |=> SUS && WRITE_IN_PROGRESS_FLAG)
    else $error("suspend not taken");
  susp_ignore_a: assert property (op_only && op_r == `FSR_OP_SUSP
    && state_r != ST_ARR |=> $stable(SUS) && state_r == $past(state_r))
    else $error("suspend acted while not allowed");
  susp_hold_a: assert property (state_r == ST_SUSW |-> WRITE_IN_PROGRESS_FLAG && SUS)
    else $error("busy or suspend wrong during latency");
  susp_state_a: assert property (SUS |-> state_r == ST_SUSW
    || state_r == ST_SUSP)
    else $error("suspend flag outside suspend");
  resume_wip_a: assert property ($fell(SUS) |-> !WRITE_IN_PROGRESS_FLAG ##[1:20] WRITE_IN_PROGRESS_FLAG)
    else $error("busy not back after resume");
  resume_src_a: assert property ($fell(SUS) |-> $past(state_r) == ST_SUSP)
    else $error("resume taken without suspend");
  entry_wel_a: assert property (state_r == ST_SERS
    && $past(state_r) != ST_SERS |-> $past(WRITE_ENABLE_LATCH_FLAG) && !WRITE_ENABLE_LATCH_FLAG)
    else $error("security erase without latch");
  entry_lock_a: assert property ((state_r == ST_SPRG || state_r == ST_SERS)
    && $past(state_r) == ST_IDLE |-> !$past(LB))
    else $error("security write while locked");
  sec_busy_a: assert property (state_r == ST_SPRG |-> WRITE_IN_PROGRESS_FLAG && !WRITE_ENABLE_LATCH_FLAG)
    else $error("program cycle flags wrong");
  oe_release_a: assert property (cs_rise |=> !SO_OE)
    else $error("output not released");
  so_edge_a: assert property ($changed(SO) |-> $past(sclk_fall))
    else $error("data moved off falling edge");
  susp_resume_c: cover property (go_resm ##[1:30] WRITE_IN_PROGRESS_FLAG);
  sec_erase_c: cover property (ers_done);
  sec_prog_c: cover property (prg_done);
  sec_read_c: cover property (SO_OE && ob_r == 3'h7);
endmodule
`default_nettype wire

// ### logic/fsr_cfg.svh
// constants for the suspend/resume and security register sequencer
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH
`define FSR_OP_WRITE_ENABLE_CMD 8'h06
`define FSR_OP_SUSP 8'h75
`define FSR_OP_RESM 8'h7A
`define FSR_OP_SERS 8'h44
`define FSR_OP_SPRG 8'h42
`define FSR_OP_SRD 8'h48
`define FSR_OP_PP 8'h02
`define FSR_OP_QPP 8'h32
`define FSR_OP_SE 8'h20
`define FSR_OP_BE32 8'h52
`define FSR_OP_BE64 8'hD8
`define FSR_OP_CE1 8'hC7
`define FSR_OP_CE2 8'h60
`define FSR_OP_WRSR1 8'h01
`define FSR_OP_WRSR2 8'h31
`define FSR_OP_WRSR3 8'h11
`define FSR_CLK_NS 10
`define FSR_RESUME_NS 200
`define FSR_RESUME_CYC (`FSR_RESUME_NS / `FSR_CLK_NS)
`define FSR_HDR_RD 9'h005
`define FSR_HDR_PRG 9'h004
`define FSR_HDR_ERS 9'h004
`define FSR_ERASED 8'hFF
`define FSR_PINS_IDLE 3'h4
`endif

// ### logic/fsr_pkg.sv
// types for the suspend/resume and security register sequencer
package fsr_pkg;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
  } fsr_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARR, ST_SUSW, ST_SUSP, ST_RESW, ST_SERS, ST_SPRG
  } fsr_state_t;
endpackage

// ### sim/fsr_host.sv
// serial host model driving the flash select, clock and data pins
`timescale 1ns/100ps
`default_nettype none
module fsr_host (
  input wire logic clk,
  output var logic cs_n,
  output var logic sclk,
  output var logic si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock idles low and stands still outside frames; 160 ns bit period
  task automatic xfer(input logic [7:0] tx [$], input int nrd, input int xb,
    output logic [7:0] rx [$]);
    int n;
    logic [7:0] d;
    rx = {};
    d = 8'h00;
    n = 8 * (tx.size() + nrd) + xb;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      sclk <= 1'b0;
      // past the sent bytes the line toggles, so stale data never looks valid
      si <= (k / 8 < tx.size()) ? tx[k / 8][7 - k % 8] : ~si;
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      d = {d[6:0], so};
      if (k % 8 == 7 && k / 8 >= tx.size()) begin
        rx.push_back(d);
      end
      repeat (8) @(posedge clk);
    end
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the suspend and security register sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk, rstn, lock_req, cs_n, sclk, si, so, so_oe, write_in_progress_flag, write_enable_latch_flag, sus, lb;
  logic [11:0] susp_block;
  logic [7:0] r [$];
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int oe_cyc = 0;
  // released line shows the inverse, so a missing drive enable is caught
  logic so_line;
  assign so_line = so_oe ? so : ~so;
  fsr_flash_seq #(.SE_TIME_NS(500), .PP_TIME_NS(500), .SUS_TIME_NS(500),
    .ARR_TIME_NS(5000)) dut (.CLK(clk), .RSTN(rstn), .CS_N(cs_n),
    .SCLK(sclk), .SI(si), .LOCK_REQ(lock_req), .SO(so), .SO_OE(so_oe),
    .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .WRITE_ENABLE_LATCH_FLAG(write_enable_latch_flag), .SUS(sus), .LB(lb), .SUSP_BLOCK(susp_block));
  fsr_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (so_oe === 1'b1)
      oe_cyc++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chkf(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chkd(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t data %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] tx [$]);
    host.xfer(tx, 0, 0, r);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000 && write_in_progress_flag !== 1'b0; i++) begin
      @(posedge clk);
    end
    chkf(write_in_progress_flag, 1'b0, "busy never cleared");
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e [$]);
    int n0;
    n0 = oe_cyc;
    host.xfer({8'h48, a[23:16], a[15:8], a[7:0], 8'h00}, e.size(), 0, r);
    chkf(oe_cyc > n0, 1'b1, "output never driven");
    for (int i = 0; i < e.size(); i++) begin
      chkd({4'h0, r[i]}, {4'h0, e[i]});
    end
    chkf(so_oe, 1'b0, "output still driven");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    cmd({8'h75});
    chkf(sus, 1'b0, "suspend taken while idle");
    cmd({8'h7A});
    chkf(sus, 1'b0, "resume without suspend");
    chkf(write_in_progress_flag, 1'b0, "resume made busy");
  endtask
  task automatic t_erase;
    cmd({8'h44});
    chkf(write_in_progress_flag, 1'b0, "erase without latch");
    cmd({8'h06});
    chkf(write_enable_latch_flag, 1'b1, "latch not set");
    host.xfer({8'h44}, 0, 3, r);
    chkf(write_in_progress_flag, 1'b0, "erase off byte boundary");
    cmd({8'h44});
    chkf(write_in_progress_flag, 1'b1, "erase not busy");
    chkf(write_enable_latch_flag, 1'b0, "latch kept");
    wait_idle();
  endtask
  task automatic t_prog;
    cmd({8'h06});
    cmd({8'h42, 8'h00, 8'h01, 8'hFE, 8'hA5, 8'h3C, 8'h5A});
    chkf(write_in_progress_flag, 1'b1, "program not busy");
    chkf(write_enable_latch_flag, 1'b0, "latch kept");
    wait_idle();
    cmd({8'h06});
    cmd({8'h42, 8'h00, 8'h03, 8'hFF, 8'h77, 8'hC3});
    wait_idle();
    rd(24'h0003FF, {8'h77, 8'hFF});
    rd(24'h0001FE, {8'hA5, 8'h3C, 8'hFF});
    rd(24'h000100, {8'h5A});
    rd(24'h000300, {8'hC3});
  endtask
  task automatic t_susp;
    cmd({8'h06});
    cmd({8'h20, 8'h12, 8'h34, 8'h56});
    chkf(write_in_progress_flag, 1'b1, "array op not busy");
    cmd({8'h7A});
    chkf(sus, 1'b0, "resume while running");
    chkf(write_in_progress_flag, 1'b1, "resume disturbed running op");
    cmd({8'h75});
    chkf(sus, 1'b1, "suspend not taken");
    chkd(susp_block, 12'h123);
    wait_idle();
    cmd({8'h75});
    chkf(sus, 1'b1, "second suspend");
    chkf(write_in_progress_flag, 1'b0, "second suspend busy");
    cmd({8'h06});
    cmd({8'h44});
    chkf(write_in_progress_flag, 1'b0, "erase while suspended");
    cmd({8'h02, 8'h00, 8'h00, 8'h00, 8'h11});
    chkf(write_in_progress_flag, 1'b0, "program while suspended");
    cmd({8'h42, 8'h00, 8'h00, 8'h00, 8'h00});
    chkf(write_in_progress_flag, 1'b0, "security program while suspended");
    cmd({8'hD8, 8'h00, 8'h00, 8'h00});
    chkf(write_in_progress_flag, 1'b0, "block erase while suspended");
    cmd({8'h7A});
    chkf(sus, 1'b0, "resume kept suspend");
    // busy returns 20 cycles after the flag drop; look one edge after it
    repeat (17) @(posedge clk);
    chkf(write_in_progress_flag, 1'b1, "resume not busy");
    wait_idle();
  endtask
  task automatic t_reset;
    cmd({8'h06});
    cmd({8'h20, 8'h00, 8'h10, 8'h00});
    cmd({8'h75});
    chkf(sus, 1'b1, "suspend not taken");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    chkf(sus, 1'b0, "suspend kept over reset");
    chkf(write_in_progress_flag, 1'b0, "busy over reset");
  endtask
  task automatic t_lock;
    lock_req <= 1'b1;
    @(posedge clk);
    lock_req <= 1'b0;
    @(posedge clk);
    chkf(lb, 1'b1, "lock not set");
    cmd({8'h06});
    cmd({8'h44});
    chkf(write_in_progress_flag, 1'b0, "erase when locked");
    cmd({8'h42, 8'h00, 8'h00, 8'h00, 8'h00});
    chkf(write_in_progress_flag, 1'b0, "program when locked");
    rd(24'h000000, {8'hFF});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    lock_req = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle();
    t_erase();
    t_prog();
    t_susp();
    t_reset();
    t_lock();
    test_done();
  end
endmodule
`default_nettype wire
